/* File: design/pcr_pkg.sv */
// Package: field layouts, select codes and timing for the PLL control words
package pcr_pkg;
    // Register-select codes in the low three bits
    localparam logic [2:0] SEL_FRACTION_NUMERATOR_WORD = 3'h0;
    localparam logic [2:0] SEL_REF_CP    = 3'h2;
    localparam logic [2:0] SEL_CLKDIV    = 3'h3;
    localparam logic [2:0] SEL_OUTSTAGE  = 3'h4;
    localparam logic [2:0] SEL_LOCKPIN   = 3'h5;
    // Reference / charge-pump word fields
    localparam int NOISE_HI      = 30;
    localparam int NOISE_LO      = 29;
    localparam int TESTSEL_HI    = 28;
    localparam int TESTSEL_LO    = 26;
    localparam int DOUBLER_BIT   = 25;
    localparam int HALVER_BIT    = 24;
    localparam int RCOUNT_HI     = 23;
    localparam int RCOUNT_LO     = 14;
    localparam int DBUF_BIT      = 13;
    localparam int CPCUR_HI      = 12;
    localparam int CPCUR_LO      = 9;
    localparam int LDFUNC_BIT    = 8;
    localparam int LDPREC_BIT    = 7;
    localparam int PDPOL_BIT     = 6;
    localparam int PWRDN_BIT     = 5;
    localparam int CPTRI_BIT     = 4;
    localparam int CNTRST_BIT    = 3;
    // Clock-divider word fields
    localparam int ABP_BIT       = 22;
    localparam int CHCANCEL_BIT  = 21;
    localparam int SLIP_BIT      = 18;
    localparam int CDMODE_HI     = 16;
    localparam int CDMODE_LO     = 15;
    localparam int CDVAL_HI      = 14;
    localparam int CDVAL_LO      = 3;
    // Output-stage word fields
    localparam int FBSEL_BIT     = 23;
    localparam int DIVSEL_HI     = 22;
    localparam int DIVSEL_LO     = 20;
    localparam int MUTE_BIT      = 10;
    localparam int RFEN_BIT      = 5;
    localparam int OPWR_HI       = 4;
    localparam int OPWR_LO       = 3;
    // Lock-pin word fields
    localparam int LDPIN_HI      = 23;
    localparam int LDPIN_LO      = 22;
    // Noise modes
    localparam logic [1:0] NOISE_LOWEST = 2'h0;
    localparam logic [1:0] NOISE_SPUR   = 2'h3;
    // Clock-divider modes
    localparam logic [1:0] CDM_OFF      = 2'h0;
    localparam logic [1:0] CDM_FASTLOCK = 2'h1;
    localparam logic [1:0] CDM_RESYNC   = 2'h2;
    // Lock pin functions
    localparam logic [1:0] LDP_LOW      = 2'h0;
    localparam logic [1:0] LDP_DIGITAL  = 2'h1;
    localparam logic [1:0] LDP_HIGH     = 2'h3;
    // Lock counts and windows
    localparam logic [5:0] LOCK_CNT_FRACTION_NUMERATOR = 6'h28;
    localparam logic [5:0] LOCK_CNT_INT  = 6'h05;
    localparam int WIN_WIDE_NS   = 10;
    localparam int WIN_NARROW_NS = 6;
    localparam int ABP_LONG_NS   = 6;
    localparam int ABP_SHORT_NS  = 3;
    localparam int WORD_W        = 32;
    localparam logic [WORD_W-1:0] WORD_RST = 32'h0000_0000;

    // Decoded settings that travel together
    typedef struct packed {
        logic       dither_en;
        logic       doubler_en;
        logic       both_edges;
        logic       halver_en;
        logic [9:0] ref_ratio;
        logic [3:0] cp_current;
        logic       cp_tristate;
        logic       counters_rst;
        logic       abp_short;
        logic       slip_en;
        logic [1:0] cd_mode;
        logic [11:0] cd_value;
        logic       fb_direct;
        logic [2:0] out_div_sel;
    } pcr_cfg_t;
endpackage

/* File: design/pcr_shifter.sv */
// Three-wire serial shifter: MSB first, word presented on load-enable rise
`timescale 1ns/1ps
module pcr_shifter #(
    parameter int W = 32
) (
    input  wire logic         mclk,
    input  wire logic         reset_n,
    input  wire logic         ser_clk,
    input  wire logic         ser_data,
    input  wire logic         ser_le,
    output logic [W-1:0]      word,
    output logic              word_vld
);
    logic [W-1:0] sh_r, sh_nxt;       // Shift register
    logic         sclk_r, le_r;       // Previous pin levels
    logic         vld_nxt;            // Load pulse next value
    logic [W-1:0] word_nxt;           // Presented word next value

    // ------------------------------------------------------------
    // Shift and load
    // ------------------------------------------------------------
    // Pins are synchronous to mclk, so edges are found by one-cycle delay
    always_comb begin
        sh_nxt   = sh_r;
        word_nxt = word;
        vld_nxt  = 1'b0;
        if (ser_clk && !sclk_r && !ser_le) begin
            sh_nxt = {sh_r[W-2:0], ser_data};
        end
        if (ser_le && !le_r) begin
            word_nxt = sh_r;
            vld_nxt  = 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            sh_r     <= '0;
            sclk_r   <= 1'b0;
            le_r     <= 1'b0;
            word     <= '0;
            word_vld <= 1'b0;
        end else begin
            sh_r     <= sh_nxt;
            sclk_r   <= ser_clk;
            le_r     <= ser_le;
            word     <= word_nxt;
            word_vld <= vld_nxt;
        end
    end
endmodule // pcr_shifter

/* File: design/pcr_lock_det.sv */
// Digital lock detector: consecutive in-window comparison cycles
`timescale 1ns/1ps
module pcr_lock_det (
    input  wire logic       mclk,
    input  wire logic       reset_n,
    input  wire logic       clr,          // Power-down only; counter reset does not clear
    input  wire logic       cmp_evt,      // One pulse per comparison cycle
    input  wire logic [7:0] phase_err_ns, // Measured phase error
    input  wire logic       int_mode,     // 1 selects integer detector
    input  wire logic       precise,      // 1 selects narrow window
    output logic            locked
);
    logic [5:0] cnt_r, cnt_nxt;     // Consecutive good cycles
    logic       lock_nxt;           // Lock flag next value
    logic [5:0] need;               // Cycles required
    logic [7:0] win;                // Active window

    // ------------------------------------------------------------
    // Count consecutive good cycles
    // ------------------------------------------------------------
    always_comb begin
        need = int_mode ? pcr_pkg::LOCK_CNT_INT
                        : pcr_pkg::LOCK_CNT_FRACTION_NUMERATOR;
        win  = precise ? 8'(pcr_pkg::WIN_NARROW_NS)
                       : 8'(pcr_pkg::WIN_WIDE_NS);
        cnt_nxt  = cnt_r;
        lock_nxt = locked;
        if (clr) begin
            cnt_nxt  = '0;
            lock_nxt = 1'b0;
        end else if (cmp_evt) begin
            if (phase_err_ns > win) begin
                cnt_nxt  = '0;
                lock_nxt = 1'b0;
            end else if (cnt_r + 6'h01 >= need) begin
                cnt_nxt  = need;
                lock_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 6'h01;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_r  <= '0;
            locked <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            locked <= lock_nxt;
        end
    end

    // Lock only after the full run of good cycles
    lock_needs_run_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !locked ##1 locked |-> $past(cnt_r) + 6'h01 >= $past(need))
        else $error("lock rose before enough good cycles");
    bad_cycle_unlocks_a: assert property (@(posedge mclk) disable iff (!reset_n)
        cmp_evt && !clr && phase_err_ns > win |=> !locked && cnt_r == 6'h00)
        else $error("bad cycle did not clear lock");
endmodule // pcr_lock_det

/* File: design/pcr_regs.sv */
// PLL control words two to five: decode, hold and apply settings
`timescale 1ns/1ps
module pcr_regs (
    input  wire logic           mclk,
    input  wire logic           reset_n,
    input  wire logic           ser_clk,
    input  wire logic           ser_data,
    input  wire logic           ser_le,
    input  wire logic           reference_input,
    input  wire logic           cmp_evt,
    input  wire logic [7:0]     phase_err_ns,
    output pcr_pkg::pcr_cfg_t   cfg,
    output logic                soft_power_down,
    output logic                ref_clk_out,
    output logic                out_enable,
    output logic                lock_pin,
    output logic [2:0]          test_output_select
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [31:0] rcp_r, rcp_nxt;     // Reference / charge-pump word
    logic [31:0] cdv_r, cdv_nxt;     // Clock-divider word
    logic [31:0] ost_r, ost_nxt;     // Output-stage word
    logic [31:0] lkp_r, lkp_nxt;     // Lock-pin word
    logic [2:0]  div_act_r, div_act_nxt; // Applied output divider
    logic [31:0] word;               // Word from the shifter
    logic        word_vld;           // One-cycle load pulse
    logic [2:0]  register_select_bits; // Low three bits of word
    logic        locked;             // Digital lock detect
    logic        pd;                 // Power-down level

    pcr_shifter #(.W(pcr_pkg::WORD_W)) u_shift (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .ser_clk  (ser_clk),
        .ser_data (ser_data),
        .ser_le   (ser_le),
        .word     (word),
        .word_vld (word_vld)
    );

    assign register_select_bits = word[2:0];
    assign pd = rcp_r[pcr_pkg::PWRDN_BIT];

    // ------------------------------------------------------------
    // Word routing
    // ------------------------------------------------------------
    // Power-down never blocks loading, so software can always wake the part
    always_comb begin
        rcp_nxt     = rcp_r;
        cdv_nxt     = cdv_r;
        ost_nxt     = ost_r;
        lkp_nxt     = lkp_r;
        div_act_nxt = div_act_r;
        if (word_vld) begin
            unique case (register_select_bits)
                pcr_pkg::SEL_REF_CP:   rcp_nxt = word;
                pcr_pkg::SEL_CLKDIV:   cdv_nxt = word;
                pcr_pkg::SEL_OUTSTAGE: begin
                    ost_nxt = word;
                    // Unbuffered: divider takes effect at once
                    if (!rcp_r[pcr_pkg::DBUF_BIT]) begin
                        div_act_nxt = word[pcr_pkg::DIVSEL_HI:
                                           pcr_pkg::DIVSEL_LO];
                    end
                end
                pcr_pkg::SEL_LOCKPIN:  lkp_nxt = word;
                pcr_pkg::SEL_FRACTION_NUMERATOR_WORD: begin
                    // Fraction word releases a held divider selection
                    div_act_nxt = ost_r[pcr_pkg::DIVSEL_HI:
                                        pcr_pkg::DIVSEL_LO];
                end
                default: ;  // Other words belong to other blocks
            endcase
        end
    end

    // Register contents persist through power-down; only reset clears them
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rcp_r     <= pcr_pkg::WORD_RST;
            cdv_r     <= pcr_pkg::WORD_RST;
            ost_r     <= pcr_pkg::WORD_RST;
            lkp_r     <= pcr_pkg::WORD_RST;
            div_act_r <= '0;
        end else begin
            rcp_r     <= rcp_nxt;
            cdv_r     <= cdv_nxt;
            ost_r     <= ost_nxt;
            lkp_r     <= lkp_nxt;
            div_act_r <= div_act_nxt;
        end
    end

    // ------------------------------------------------------------
    // Reference path: counter and halver
    // ------------------------------------------------------------
    logic [9:0] rcnt_r, rcnt_nxt;    // Reference counter
    logic       reference_input_r;             // Previous reference level
    logic       half_r, half_nxt;    // Halver toggle
    logic       rpulse_r, rpulse_nxt;// Counter output
    logic       ref_edge;            // Active reference edge
    logic       cnt_hold;            // Counters held in load state
    logic [9:0] ratio;               // Programmed ratio

    assign ratio = rcp_r[pcr_pkg::RCOUNT_HI:pcr_pkg::RCOUNT_LO];
    // Falling edge only, or both edges when the doubler runs
    assign ref_edge = rcp_r[pcr_pkg::DOUBLER_BIT]
                    ? (reference_input ^ reference_input_r)
                    : (!reference_input && reference_input_r);
    assign cnt_hold = pd || rcp_r[pcr_pkg::CNTRST_BIT];

    // Ratio 0 is illegal; it is treated as 1 rather than stalling
    always_comb begin
        rcnt_nxt   = rcnt_r;
        half_nxt   = half_r;
        rpulse_nxt = 1'b0;
        if (cnt_hold) begin
            rcnt_nxt = '0;
            half_nxt = 1'b0;
        end else if (ref_edge) begin
            if (rcnt_r + 10'h001 >= ratio) begin
                rcnt_nxt   = '0;
                rpulse_nxt = 1'b1;
                half_nxt   = !half_r;
            end else begin
                rcnt_nxt = rcnt_r + 10'h001;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rcnt_r   <= '0;
            reference_input_r  <= 1'b0;
            half_r   <= 1'b0;
            rpulse_r <= 1'b0;
        end else begin
            rcnt_r   <= rcnt_nxt;
            reference_input_r  <= reference_input;
            half_r   <= half_nxt;
            rpulse_r <= rpulse_nxt;
        end
    end

    counter_held_a: assert property (@(posedge mclk) disable iff (!reset_n)
        rcp_r[pcr_pkg::CNTRST_BIT] |=> rcnt_r == 10'h000)
        else $error("reference counter ran while held");

    // ------------------------------------------------------------
    // Lock detection
    // ------------------------------------------------------------
    pcr_lock_det u_lock (
        .mclk         (mclk),
        .reset_n      (reset_n),
        .clr          (pd),
        .cmp_evt      (cmp_evt),
        .phase_err_ns (phase_err_ns),
        .int_mode     (rcp_r[pcr_pkg::LDFUNC_BIT]),
        .precise      (rcp_r[pcr_pkg::LDPREC_BIT]),
        .locked       (locked)
    );

    // ------------------------------------------------------------
    // Decoded outputs
    // ------------------------------------------------------------
    pcr_pkg::pcr_cfg_t cfg_nxt;     // Decoded settings
    logic ref_nxt, oe_nxt, pin_nxt; // Output next values

    always_comb begin
        cfg_nxt.dither_en   = rcp_r[pcr_pkg::NOISE_HI:pcr_pkg::NOISE_LO]
                              == pcr_pkg::NOISE_SPUR;
        cfg_nxt.doubler_en  = rcp_r[pcr_pkg::DOUBLER_BIT];
        cfg_nxt.both_edges  = rcp_r[pcr_pkg::DOUBLER_BIT];
        cfg_nxt.halver_en   = rcp_r[pcr_pkg::HALVER_BIT];
        cfg_nxt.ref_ratio   = ratio;
        cfg_nxt.cp_current  = rcp_r[pcr_pkg::CPCUR_HI:pcr_pkg::CPCUR_LO];
        // Pump floats on its own bit or in power-down
        cfg_nxt.cp_tristate = rcp_r[pcr_pkg::CPTRI_BIT] || pd;
        cfg_nxt.counters_rst = cnt_hold;
        cfg_nxt.abp_short   = cdv_r[pcr_pkg::ABP_BIT];
        cfg_nxt.slip_en     = cdv_r[pcr_pkg::SLIP_BIT];
        cfg_nxt.cd_mode     = cdv_r[pcr_pkg::CDMODE_HI:pcr_pkg::CDMODE_LO];
        cfg_nxt.cd_value    = cdv_r[pcr_pkg::CDVAL_HI:pcr_pkg::CDVAL_LO];
        cfg_nxt.fb_direct   = ost_r[pcr_pkg::FBSEL_BIT];
        cfg_nxt.out_div_sel = div_act_r;
        // Comparator clock: halved toggle or raw counter pulse
        ref_nxt = rcp_r[pcr_pkg::HALVER_BIT] ? half_r : rpulse_r;
        // Output off in power-down, or muted until lock
        oe_nxt  = !pd && ost_r[pcr_pkg::RFEN_BIT]
                  && !(ost_r[pcr_pkg::MUTE_BIT] && !locked);
        unique case (lkp_r[pcr_pkg::LDPIN_HI:pcr_pkg::LDPIN_LO])
            pcr_pkg::LDP_DIGITAL: pin_nxt = locked;
            pcr_pkg::LDP_HIGH:    pin_nxt = 1'b1;
            default:              pin_nxt = 1'b0;              // Both low codes
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cfg                <= '0;
            soft_power_down    <= 1'b0;
            ref_clk_out        <= 1'b0;
            out_enable         <= 1'b0;
            lock_pin           <= 1'b0;
            test_output_select <= '0;
        end else begin
            cfg                <= cfg_nxt;
            soft_power_down    <= pd;
            ref_clk_out        <= ref_nxt;
            out_enable         <= oe_nxt;
            lock_pin           <= pin_nxt;
            test_output_select <= rcp_r[pcr_pkg::TESTSEL_HI:pcr_pkg::TESTSEL_LO];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    route_ref_word_a: assert property (@(posedge mclk) disable iff (!reset_n)
        word_vld && word[2:0] == pcr_pkg::SEL_REF_CP |=> rcp_r == $past(word))
        else $error("reference word not stored");
    route_lockpin_a: assert property (@(posedge mclk) disable iff (!reset_n)
        word_vld && word[2:0] != pcr_pkg::SEL_LOCKPIN |=> $stable(lkp_r))
        else $error("lock-pin word changed by other select");
    dbuf_holds_div_a: assert property (@(posedge mclk) disable iff (!reset_n)
        word_vld && word[2:0] == pcr_pkg::SEL_OUTSTAGE
        && rcp_r[pcr_pkg::DBUF_BIT] |=> $stable(div_act_r))
        else $error("buffered divider applied early");
    dither_mode_a: assert property (@(posedge mclk) disable iff (!reset_n)
        ##1 cfg.dither_en == ($past(rcp_r[pcr_pkg::NOISE_HI:pcr_pkg::NOISE_LO])
        == pcr_pkg::NOISE_SPUR))
        else $error("dither does not follow noise mode");
    mute_till_lock_a: assert property (@(posedge mclk) disable iff (!reset_n)
        ost_r[pcr_pkg::MUTE_BIT] && !locked |=> !out_enable)
        else $error("output enabled before lock");
    pd_disables_out_a: assert property (@(posedge mclk) disable iff (!reset_n)
        pd |=> !out_enable && cfg.cp_tristate ##1 !u_lock.locked)
        else $error("power-down left outputs active");
    lock_pin_high_a: assert property (@(posedge mclk) disable iff (!reset_n)
        lkp_r[pcr_pkg::LDPIN_HI:pcr_pkg::LDPIN_LO] == pcr_pkg::LDP_HIGH
        |=> lock_pin)
        else $error("lock pin not high");
endmodule // pcr_regs

/* File: dv/pcr_host.sv */
// Host model: writes control words over the three-wire serial link
`timescale 1ns/1ps
module pcr_host (
    input  wire logic mclk,
    output logic      ser_clk,
    output logic      ser_data,
    output logic      ser_le
);
    // ---------------------------------------------
    // Idle levels
    // ---------------------------------------------
    initial begin
        ser_clk  = 1'b0;
        ser_data = 1'b0;
        ser_le   = 1'b0;
    end

    // One word, MSB first, then a load-enable pulse
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            @(posedge mclk) ser_clk <= 1'b0;
            ser_data <= w[i];
            @(posedge mclk) ser_clk <= 1'b1;
        end
        @(posedge mclk) ser_clk <= 1'b0;
        // Released data line must not keep the last bit
        ser_data <= ~w[0];
        @(posedge mclk) ser_le <= 1'b1;
        @(posedge mclk) ser_le <= 1'b0;
        // Margin past the three-edge apply latency
        repeat (5) @(posedge mclk);
    endtask
endmodule // pcr_host

/* File: dv/pll_control_registers_two_to_five_tb.sv */
// Bench: word routing, field decode, lock detect and power-down
`timescale 1ns/1ps
module pll_control_registers_two_to_five_tb;
    // ---------------------------------------------
    // Signals
    // ---------------------------------------------
    logic              mclk, reset_n, ref_in, cmp_evt;
    logic [7:0]        perr;             // Phase error of an event
    logic              sck, sdi, sle;    // Serial link
    logic              pd, oen, lpin;    // Status outputs
    logic              rclk;             // Comparator clock output
    logic [2:0]        tos;              // Test output selection
    pcr_pkg::pcr_cfg_t cfg, e;           // Actual and expected
    int                fail_count  = 0;
    int                checks_done = 0;

    pcr_host host_u (.mclk(mclk), .ser_clk(sck), .ser_data(sdi),
                     .ser_le(sle));
    pcr_regs dut_u (.mclk(mclk), .reset_n(reset_n), .ser_clk(sck),
        .ser_data(sdi), .ser_le(sle), .reference_input(ref_in),
        .cmp_evt(cmp_evt), .phase_err_ns(perr), .cfg(cfg),
        .soft_power_down(pd), .ref_clk_out(rclk), .out_enable(oen),
        .lock_pin(lpin), .test_output_select(tos));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // Reference keeps toggling so its edge logic is exercised
    always @(posedge mclk) ref_in <= ~ref_in;

    // ---------------------------------------------
    // Compares, word builders, event driver
    // ---------------------------------------------
    task automatic chk_cfg(input pcr_pkg::pcr_cfg_t g, x);
        checks_done++;
        if (g !== x) begin
            fail_count++;
            $display("BAD %0t cfg %h exp %h", $time, g, x);
        end
    endtask
    task automatic chk_bit(input logic g, x);
        checks_done++;
        if (g !== x) begin
            fail_count++;
            $display("BAD %0t pin %b exp %b", $time, g, x);
        end
    endtask
    function automatic logic [31:0] w_ref(input logic [1:0] n,
                                          input logic db, pw, cr, im);
        return {1'b0, n, 3'h0, 2'h3, 10'h155, db, 4'hA, im, 2'h0, pw,
                1'b0, cr, pcr_pkg::SEL_REF_CP};
    endfunction
    function automatic logic [31:0] w_cd(input logic [1:0] m);
        return {9'h0, 1'b1, 3'h0, 1'b1, 1'b0, m, 12'hABC,
                pcr_pkg::SEL_CLKDIV};
    endfunction
    function automatic logic [31:0] w_out(input logic f,
                                          input logic [2:0] d,
                                          input logic m);
        return {8'h0, f, d, 9'h0, m, 4'h0, 1'b1, 2'h0,
                pcr_pkg::SEL_OUTSTAGE};
    endfunction
    function automatic logic [31:0] w_lp(input logic [1:0] c);
        return {8'h0, c, 19'h0, pcr_pkg::SEL_LOCKPIN};
    endfunction
    task automatic ev(input int k, input logic [7:0] err);
        repeat (k) begin
            @(posedge mclk) cmp_evt <= 1'b1;
            perr <= err;
            @(posedge mclk) cmp_evt <= 1'b0;
        end
        repeat (4) @(posedge mclk);
    endtask

    // ---------------------------------------------
    // Scenarios
    // ---------------------------------------------
    task automatic t_init;
        host_u.send(w_lp(pcr_pkg::LDP_DIGITAL));
        host_u.send(w_out(1'b1, 3'h3, 1'b0));
        host_u.send(w_cd(pcr_pkg::CDM_RESYNC));
        host_u.send(w_ref(2'h3, 1'b0, 1'b0, 1'b0, 1'b0));
        host_u.send(32'h0000_0001);
        host_u.send(32'h0000_0000);
        e = {4'hF, 10'h155, 4'hA, 2'h0, 2'h3, pcr_pkg::CDM_RESYNC,
             12'hABC, 1'b1, 3'h3};
        chk_cfg(cfg, e);
    endtask
    task automatic t_modes;
        for (int n = 0; n < 4; n++) begin
            host_u.send(w_ref(n[1:0], 1'b0, 1'b0, 1'b0, 1'b0));
            e.dither_en = (n == 3);
            chk_cfg(cfg, e);
        end
        for (int m = 0; m < 3; m++) begin
            host_u.send(w_cd(m[1:0]));
            e.cd_mode = m[1:0];
            chk_cfg(cfg, e);
        end
    endtask
    // Unused select codes must leave every setting alone
    task automatic t_refused;
        host_u.send(32'hFFFF_FFF9);
        host_u.send(32'hFFFF_FFFE);
        host_u.send(32'hFFFF_FFFF);
        chk_cfg(cfg, e);
    endtask
    task automatic t_dbuf;
        host_u.send(w_ref(2'h3, 1'b1, 1'b0, 1'b0, 1'b0));
        host_u.send(w_out(1'b0, 3'h6, 1'b0));
        e.fb_direct = 1'b0;
        chk_cfg(cfg, e);
        host_u.send(32'h0000_0000);
        e.out_div_sel = 3'h6;
        chk_cfg(cfg, e);
        host_u.send(w_ref(2'h3, 1'b0, 1'b0, 1'b1, 1'b0));
        e.counters_rst = 1'b1;
        chk_cfg(cfg, e);
        chk_bit(rclk, 1'b0);
        host_u.send(w_ref(2'h3, 1'b0, 1'b0, 1'b0, 1'b0));
        e.counters_rst = 1'b0;
        chk_cfg(cfg, e);
        // Both edges counted, ratio 341: halver toggles once in 400
        repeat (400) @(posedge mclk);
        chk_bit(rclk, 1'b1);
    endtask
    // Window edge of 10 ns counts as good; 11 ns breaks the run
    task automatic t_lock;
        host_u.send(w_ref(2'h3, 1'b0, 1'b0, 1'b0, 1'b1));
        host_u.send(w_out(1'b0, 3'h6, 1'b1));
        chk_bit(oen, 1'b0);
        ev(4, 8'h0A);
        chk_bit(lpin, 1'b0);
        ev(1, 8'h0A);
        chk_bit(lpin, 1'b1);
        chk_bit(oen, 1'b1);
        ev(1, 8'h0B);
        chk_bit(lpin, 1'b0);
        host_u.send(w_ref(2'h3, 1'b0, 1'b0, 1'b0, 1'b0));
        ev(39, 8'h05);
        chk_bit(lpin, 1'b0);
        ev(1, 8'h05);
        chk_bit(lpin, 1'b1);
    endtask
    task automatic t_pd;
        host_u.send(w_ref(2'h3, 1'b0, 1'b1, 1'b0, 1'b0));
        chk_bit(pd, 1'b1);
        chk_bit(lpin, 1'b0);
        chk_bit(oen, 1'b0);
        host_u.send(w_lp(pcr_pkg::LDP_HIGH));
        chk_bit(lpin, 1'b1);
        host_u.send(w_lp(pcr_pkg::LDP_LOW));
        chk_bit(lpin, 1'b0);
        host_u.send(w_ref(2'h3, 1'b0, 1'b0, 1'b0, 1'b0));
        chk_bit(pd, 1'b0);
        chk_cfg(cfg, e);
        // Test selection bits 28 and 26 set, nothing else moves
        host_u.send(w_ref(2'h3, 1'b0, 1'b0, 1'b0, 1'b0) | 32'h1400_0000);
        chk_bit(tos == 3'h5, 1'b1);
        chk_cfg(cfg, e);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        reset_n = 1'b0;
        ref_in  = 1'b0;
        cmp_evt = 1'b0;
        perr    = 8'h00;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_init;
        t_modes;
        t_refused;
        t_dbuf;
        t_lock;
        t_pd;
        tally_and_finish;
    end
    // About 3000 cycles expected; 10000 means a hang
    initial begin
        #200000;
        fail_count++;
        tally_and_finish;
    end
endmodule // pll_control_registers_two_to_five_tb
